// [ets_monoflop.sv]
// Retriggerable monoflop that flags an idle shift clock
`timescale 1ns/1ns
`default_nettype none
module ets_monoflop (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_edge,
  input wire logic [15:0] span,
  output logic idle
);
  logic [15:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      idle <= 1'b1;
    end else if (clk_edge) begin
      cnt_r <= 16'h0000;
      idle <= 1'b0;
    end else if (cnt_r >= span) begin
      idle <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // ets_monoflop
`default_nettype wire

// [ets_pkg.sv]
// Constants, field layouts and enumerations for the encoder test and chain block
`default_nettype none
package ets_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Internal monoflop span used when no timing network is fitted
  localparam int TMF_NS = 20000;
  localparam logic [15:0] MF_DEF_CYC = 16'(TMF_NS / CLK_PERIOD_NS);

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MF = 8'h08;

  localparam int CFG_TEST_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam int CFG_TP_BIT = 2;
  localparam int CFG_SYNC_LSB = 3;
  localparam int CFG_DIRN_BIT = 5;
  localparam int CFG_INVN_BIT = 6;
  localparam int CFG_PHASE_BIT = 7;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'hFA;
  localparam logic [15:0] MF_RESET = 16'h0000;

  localparam int ST_SEL_LSB = 0;
  localparam int ST_TR_LSB = 5;
  localparam int ST_W_LSB = 10;
  localparam int ST_IDLE_BIT = 15;
  localparam int ST_IDDQ_BIT = 16;
  localparam int ST_RISE_LSB = 17;
  localparam int ST_WIN_BIT = 20;

  localparam logic [4:0] MSB_MASK = 5'h10;
  localparam logic [2:0] RISE_MAX = 3'h7;
  localparam logic [2:0] NSBIN_BLANK = 3'h2;

  typedef enum logic [1:0] {
    SYNC_SSI = 2'b00,
    SYNC_OUT = 2'b01,
    SYNC_NOSYNC_BIN = 2'b10,
    SYNC_NOSYNC = 2'b11
  } ets_sync_e;

  typedef enum logic [1:0] {
    TM_NORMAL = 2'b00,
    TM_ANALOG = 2'b01,
    TM_DIGITAL = 2'b10,
    TM_PROBE = 2'b11
  } ets_tmode_e;
endpackage
`default_nettype wire

// [ets_ssi_master.sv]
// Behavioural SSI master driving the shift clock and chain input
`timescale 1ns/1ns
`default_nettype none
module ets_ssi_master (
  output logic shift_clk,
  output logic chain_data_in,
  input wire logic chain_data_out
);
  initial begin
    shift_clk = 1'h1;
    chain_data_in = 1'h0;
  end
  // Idle gap well past the monoflop span, so the first fall captures a word
  task automatic frame(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    #1003;
    for (int i = n - 1; i >= 0; i--) begin
      chain_data_in = tx[i];
      #3 shift_clk = 1'h0;
      #62 shift_clk = 1'h1;
      // Sampled late in the high phase, after the output has settled
      #60 rx = {rx[6:0], chain_data_out};
    end
    // Released line shows the inverse, never a stale level
    chain_data_in = ~chain_data_in;
  endtask
endmodule // ets_ssi_master
`default_nettype wire

// [ets_sync3.sv]
// Three-stage input synchroniser, accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module ets_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] st1_r;
  logic [W-1:0] st2_r;
  logic [W-1:0] st3_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st1_r <= '0;
      st2_r <= '0;
      st3_r <= '0;
    end else begin
      st1_r <= async_in;
      st2_r <= st1_r;
      st3_r <= st2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          sync_out[i] <= 1'b0;
        end else if (st2_r[i] == st3_r[i]) begin
          sync_out[i] <= st3_r[i];
        end
      end
    end
  endgenerate
endmodule // ets_sync3
`default_nettype wire

// [ets_top.sv]
// Encoder test modes and serial chain synchronisation with an AHB-Lite register slave
// What this block does
// - Test enable high enters test; mode high digital test, low analog test.
// - Analog test: 5-bit select register shifts chain input on falling shift clock.
// - Analog test: output is XOR of all selected comparator outputs.
// - Select bits 4 to 0 pick track sensors 4 to 0.
// - Analog test with direction invert low enters quiescent current test.
// - Digital test: chain input passes a 5-bit test register before output register.
// - Digital test: after idle, first falling edge captures test register, not tracks.
// - Digital test keeps synchronisation against chain input and serial mode setup.
// - Unsynchronised binary mode accepts no stimuli into the test register.
// - Threshold probe drives XOR of inputs onto fault output, push-pull.
// - Sync-out mode presents the synchronised top bit from the first falling edge onward.
// - Synchronisation may finish by second falling edge; output briefly unstable.
// - Predecessor top bit arriving on first rising edge is still synchronised.
// - Synchronised modes contribute full data after four rising edges; sync-out mode here does so after three.
// - Monoflop detects idle clock; span from timing register or internal default.
// - Chain input sampled on falling edges, output updated on rising edges.
// - Sync select picks Gray, binary, sync-out or SSI-out serial format.
// - SSI-out holds top bit high until first rising edge, then presents it.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ets_top
  import ets_pkg::*;
#(
  parameter logic [15:0] MF_DEFAULT_CYC = MF_DEF_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic shift_clk,
  input wire logic chain_data_in,
  input wire logic [4:0] track_sensor,
  input wire logic led_fault_n,
  output logic chain_data_out,
  output logic fault_out_n,
  output logic fault_out_n_oe,
  output logic iddq_test
);
  logic [7:0] syn;
  logic [CFG_W-1:0] cfg_r;
  logic [15:0] mf_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic sclk_q_r;
  logic [4:0] sel_r;
  logic [4:0] tr_r;
  logic [4:0] w_r;
  logic [4:0] cap_r;
  logic smp_r;
  logic [2:0] rise_cnt_r;
  logic win_r;
  logic idle;
  logic [4:0] bin;

  // Pin levels pass three stages before use
  ets_sync3 #(.W(8)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({led_fault_n, track_sensor, chain_data_in, ~shift_clk}),
    .sync_out(syn)
  );

  // Clock enters inverted so the reset level of the stages matches its idle high,
  // otherwise a false fall and rise would follow every reset
  wire sclk_l = ~syn[0];
  wire din_l = syn[1];
  wire [4:0] trk_l = syn[6:2];
  wire led_fault_n_l = syn[7];
  wire fall = sclk_q_r & ~sclk_l;
  wire rise = ~sclk_q_r & sclk_l;

  wire test_en = cfg_r[CFG_TEST_BIT];
  wire mode = cfg_r[CFG_MODE_BIT];
  wire tp = cfg_r[CFG_TP_BIT];
  wire dir_n = cfg_r[CFG_DIRN_BIT];
  wire inv_n = cfg_r[CFG_INVN_BIT];
  wire phase = cfg_r[CFG_PHASE_BIT];
  wire [1:0] sync_sel = cfg_r[CFG_SYNC_LSB +: 2];
  // Decoded straight from the live setting so a change needs no reset
  ets_tmode_e tmode;
  assign tmode = !test_en ? TM_NORMAL : tp ? TM_PROBE : mode ? TM_DIGITAL : TM_ANALOG;
  ets_sync_e smode;
  assign smode = ets_sync_e'(sync_sel);

  wire analog = (tmode == TM_ANALOG);
  wire digital = (tmode == TM_DIGITAL);
  wire serial_on = digital || (tmode == TM_NORMAL && mode);
  wire nsbin = (smode == SYNC_NOSYNC_BIN);
  wire synced = (smode == SYNC_SSI) || (smode == SYNC_OUT);
  wire [15:0] mf_span = (mf_r == MF_RESET) ? MF_DEFAULT_CYC : mf_r;

  ets_monoflop u_mf (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_edge(fall | rise),
    .span(mf_span),
    .idle(idle)
  );

  wire capture = serial_on && fall && idle;
  wire mid_fall = serial_on && fall && !idle;
  // Test register stands in for the tracks on capture
  wire [4:0] src = digital ? tr_r : trk_l;
  wire [4:0] inv = src ^ (dir_n ? 5'h00 : MSB_MASK) ^ (inv_n ? 5'h00 : 5'h1F);

  assign bin[4] = inv[4];
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_g2b
      assign bin[i] = bin[i+1] ^ inv[i];
    end
  endgenerate

  wire [4:0] word_cap = (smode == SYNC_NOSYNC) ? inv : bin;
  // Own sync track against predecessor top bit, live through the window
  wire [3:0] up4 = cap_r[4:1];
  wire sbit = cap_r[0] ^ ~phase;
  wire [3:0] corr = (sbit && !din_l) ? 4'(up4 + 4'h1) :
                    (!sbit && din_l) ? 4'(up4 - 4'h1) : up4;
  wire feed = digital ? tr_r[4] : din_l;
  wire accept = !(nsbin && rise_cnt_r < NSBIN_BLANK);
  wire [2:0] top = (smode == SYNC_SSI) ? 3'h3 : (smode == SYNC_OUT) ? 3'h2 : 3'h4;
  wire [4:0] w_sync = (smode == SYNC_SSI) ? {1'b0, corr[2:0], smp_r} :
                      {2'b00, corr[1:0], smp_r};
  wire sel_xor = ^(sel_r & trk_l);
  wire win_bit = (smode == SYNC_SSI) ? ((rise_cnt_r == 3'h0) ? 1'b1 : corr[3]) :
                 ((rise_cnt_r == 3'h0) ? corr[3] : corr[2]);
  wire out_nxt = analog ? sel_xor :
                 (serial_on && win_r) ? win_bit :
                 (serial_on && rise) ? w_r[top] : chain_data_out;
  wire probe_xor = ^{sync_sel, din_l, sclk_l, dir_n, inv_n, phase};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b1;
      sel_r <= 5'h00;
      tr_r <= 5'h00;
      iddq_test <= 1'b0;
    end else begin
      sclk_q_r <= sclk_l;
      if (analog && fall) begin
        sel_r <= {sel_r[3:0], din_l};
      end
      if (digital && fall && !nsbin) begin
        tr_r <= {tr_r[3:0], din_l};
      end
      iddq_test <= analog && !dir_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      w_r <= 5'h00;
      cap_r <= 5'h00;
      smp_r <= 1'b0;
      rise_cnt_r <= 3'h0;
      win_r <= 1'b0;
    end else if (capture) begin
      w_r <= word_cap;
      cap_r <= bin;
      smp_r <= feed;
      rise_cnt_r <= 3'h0;
      win_r <= synced;
    end else if (mid_fall) begin
      smp_r <= feed;
      if (win_r && rise_cnt_r != 3'h0) begin
        win_r <= 1'b0;
        w_r <= w_sync;
      end
    end else if (serial_on && rise) begin
      if (rise_cnt_r != RISE_MAX) begin
        rise_cnt_r <= rise_cnt_r + 3'h1;
      end
      if (!win_r) begin
        w_r <= {w_r[3:0], accept ? smp_r : 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chain_data_out <= 1'b1;
      fault_out_n <= 1'b0;
      fault_out_n_oe <= 1'b0;
    end else begin
      chain_data_out <= out_nxt;
      if (tmode == TM_PROBE) begin
        fault_out_n <= probe_xor;
        fault_out_n_oe <= 1'b1;
      end else begin
        fault_out_n <= 1'b0;
        fault_out_n_oe <= !led_fault_n_l;
      end
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire addr_ok = hsel && htrans[1] && hready;
  wire [7:0] a_lo = haddr[7:0];
  wire [31:0] stat = {11'h000, win_r, rise_cnt_r, iddq_test, idle, w_r, tr_r, sel_r};
  wire [31:0] rd_mux = (a_lo == ADDR_CFG) ? {24'h000000, cfg_r} :
                       (a_lo == ADDR_STAT) ? stat :
                       (a_lo == ADDR_MF) ? {16'h0000, mf_r} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cfg_r <= CFG_RESET;
      mf_r <= MF_RESET;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_r <= a_lo;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_r && addr_r == ADDR_CFG) begin
        cfg_r <= hwdata[CFG_W-1:0];
      end
      if (wr_pend_r && addr_r == ADDR_MF) begin
        mf_r <= hwdata[15:0];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  analog_xor_a: assert property (analog && $past(analog) |=> chain_data_out == $past(sel_xor, 1))
    else $error("analog output is not the xor of selected tracks");
  select_shift_a: assert property (analog && fall |=> sel_r == {$past(sel_r[3:0]), $past(din_l)})
    else $error("track select register did not shift");
  test_shift_a: assert property (digital && fall && !nsbin |=> tr_r[0] == $past(din_l))
    else $error("test register did not take chain input");
  no_stimuli_a: assert property (nsbin && $past(nsbin) |-> $stable(tr_r))
    else $error("test register changed in binary unsynchronised mode");
  test_capture_a: assert property (capture && digital && smode == SYNC_NOSYNC |=> w_r == ($past(tr_r) ^ ($past(dir_n) ? 5'h00 : MSB_MASK) ^ ($past(inv_n) ? 5'h00 : 5'h1F)))
    else $error("capture did not load the test register");
  probe_out_a: assert property (tmode == TM_PROBE |=> fault_out_n_oe && fault_out_n == $past(probe_xor))
    else $error("probe output wrong");
  ssi_hold_a: assert property (serial_on && win_r && smode == SYNC_SSI && rise_cnt_r == 3'h0 ##1 serial_on && win_r |-> chain_data_out)
    else $error("ssi top bit not held high before first rising edge");
  rise_update_a: assert property (serial_on && rise && !win_r && !analog |=> chain_data_out == $past(w_r[top]))
    else $error("output not updated on rising edge");
  iddq_flag_a: assert property (analog && !dir_n |=> iddq_test)
    else $error("quiescent current test not entered");
  sync_close_a: assert property (win_r && mid_fall && rise_cnt_r != 3'h0 |=> !win_r ##0 w_r == $past(w_sync))
    else $error("synchronisation window did not close on second falling edge");

  // Registers that must stay put outside their own shift condition, then edge, window, count, write and fault pin checks
  select_hold_a: assert property (!(analog && fall) |=> $stable(sel_r))
    else $error("track select register moved without a falling edge");
  test_hold_a: assert property (!(digital && fall && !nsbin) |=> $stable(tr_r))
    else $error("test register moved without a stimulus edge");
  iddq_clear_a: assert property (!(analog && !dir_n) |=> !iddq_test)
    else $error("quiescent current flag set outside its mode");
  idle_retrig_a: assert property ((fall || rise) |=> !idle)
    else $error("monoflop not retriggered by a clock edge");
  sync_open_a: assert property (capture && synced |=> win_r && rise_cnt_r == 3'h0)
    else $error("synchronisation window not opened on capture");
  sync_out_live_a: assert property (serial_on && win_r && rise_cnt_r == 3'h0 && smode == SYNC_OUT |=> chain_data_out == $past(corr[3]))
    else $error("corrected top bit not presented in sync window");
  nsbin_blank_a: assert property (serial_on && rise && !win_r && nsbin && rise_cnt_r < NSBIN_BLANK |=> !w_r[0])
    else $error("binary mode accepted chain data on an early rising edge");
  rise_count_a: assert property (serial_on && rise && rise_cnt_r != RISE_MAX |=> rise_cnt_r == $past(rise_cnt_r) + 3'h1)
    else $error("rising edge count did not advance");
  cfg_write_a: assert property (wr_pend_r && addr_r == ADDR_CFG |=> cfg_r == $past(hwdata[CFG_W-1:0]))
    else $error("mode setting not taken from the write");
  normal_fault_a: assert property (tmode != TM_PROBE |=> !fault_out_n && fault_out_n_oe == !$past(led_fault_n_l))
    else $error("fault pin not open drain outside probe mode");
endmodule // ets_top
`default_nettype wire

// [ets_top_bench.sv]
// Self-checking bench for the encoder test and chain block
`timescale 1ns/1ns
`default_nettype none
module ets_top_bench
  import ets_pkg::*;
;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, shift_clk, chain_data_in, chain_data_out;
  logic fault_out_n, fault_out_n_oe, iddq_test;
  logic [4:0] track_sensor = 5'h00;
  logic led_fault_n = 1'h1;
  logic rd_dp = 1'h0;
  logic [63:0] exp_q[$];
  logic [63:0] mq;
  logic [31:0] rng = 32'h00005D9C;
  logic [7:0] rx;
  int failures = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  ets_top #(.MF_DEFAULT_CYC(16'h0032)) dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .shift_clk(shift_clk), .chain_data_in(chain_data_in), .track_sensor(track_sensor),
    .led_fault_n(led_fault_n), .chain_data_out(chain_data_out), .fault_out_n(fault_out_n),
    .fault_out_n_oe(fault_out_n_oe), .iddq_test(iddq_test));
  ets_ssi_master ssi (.shift_clk(shift_clk), .chain_data_in(chain_data_in),
    .chain_data_out(chain_data_out));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Read data taken at the edge that ends the data phase
  always @(posedge mclk) begin
    if (rd_dp && hreadyout === 1'h1) begin
      mq = exp_q.pop_front();
      chk(mq[31:0], hrdata & mq[63:32]);
      chk(32'h0, {31'h0, hresp});
    end
  end
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge mclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      exp_q.push_back({m, d & m});
      rd_dp <= 1'h1;
    end
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rd_dp <= 1'h0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    ahb(ADDR_CFG, 1'h0, {24'h0, CFG_RESET}, 32'hFFFFFFFF);
    ahb(ADDR_MF, 1'h0, 32'h0, 32'hFFFFFFFF);
    ahb(8'h0C, 1'h0, 32'h0, 32'hFFFFFFFF);
    ahb(ADDR_MF, 1'h1, 32'h00000040, 32'h0);
    ahb(ADDR_MF, 1'h0, 32'h00000040, 32'hFFFFFFFF);
    @(posedge mclk);
    rng = nxt(rng);
    track_sensor <= rng[4:0];
    ssi.frame(6, 8'h20, rx);
    chk({26'h0, rng[4:0], 1'h1}, {26'h0, rx[5:0]});
    ahb(ADDR_CFG, 1'h1, 32'h000000F9, 32'h0);
    ssi.frame(5, 8'h00, rx);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        ssi.frame(5, 8'h1F, rx);
        ahb(ADDR_STAT, 1'h0, 32'h0000001F, 32'h0000001F);
      end
      @(posedge mclk);
      rng = nxt(rng);
      track_sensor <= rng[4:0];
      repeat (10) @(posedge mclk);
      chk({31'h0, (i >= 2) ? ^rng[4:0] : 1'h0}, {31'h0, chain_data_out});
    end
    ahb(ADDR_CFG, 1'h1, 32'h000000D9, 32'h0);
    repeat (8) @(posedge mclk);
    chk(32'h1, {31'h0, iddq_test});
    for (int i = 0; i < 6; i++) begin
      rng = nxt(rng);
      ahb(ADDR_CFG, 1'h1, {24'h0, rng[7:3], 3'h5}, 32'h0);
      repeat (8) @(posedge mclk);
      chk({31'h1, ^rng[7:3] ^ chain_data_in ^ shift_clk},
          {30'h0, fault_out_n_oe, fault_out_n});
    end
    // Load stimuli, then show the binary mode leaves them alone
    ahb(ADDR_CFG, 1'h1, 32'h000000FB, 32'h0);
    ssi.frame(5, 8'h1F, rx);
    ahb(ADDR_STAT, 1'h0, 32'h000003E0, 32'h000003E0);
    ahb(ADDR_CFG, 1'h1, 32'h000000F3, 32'h0);
    ssi.frame(5, 8'h00, rx);
    ahb(ADDR_STAT, 1'h0, 32'h000003E0, 32'h000003E0);
    ahb(ADDR_CFG, 1'h1, 32'h000000FB, 32'h0);
    track_sensor <= 5'h00;
    ssi.frame(6, 8'h00, rx);
    chk(32'h0000003E, {26'h0, rx[5:1], 1'h0});
    // Gray 1D is binary 16; own track 0 and a low predecessor leave 4'hB
    track_sensor <= 5'h1D;
    for (int m = 0; m < 2; m++) begin
      ahb(ADDR_CFG, 1'h1, (m == 0) ? 32'h000000E2 : 32'h000000EA, 32'h0);
      ssi.frame(5, 8'h00, rx);
      chk((m == 0) ? 32'h00000016 : 32'h0000000C, {27'h0, rx[4:0]});
    end
    ahb(ADDR_CFG, 1'h1, {24'h0, CFG_RESET}, 32'h0);
    led_fault_n <= 1'h0;
    repeat (8) @(posedge mclk);
    chk(32'h2, {30'h0, fault_out_n_oe, fault_out_n});
    repeat (4) @(posedge mclk);
    test_done();
  end
endmodule // ets_top_bench
`default_nettype wire
